// [verilog/paged_regfile_pkg.sv]
`default_nettype none
package paged_regfile_pkg;
  localparam logic [7:0] SLICE_LOW_OFS = 8'h00D6;
  localparam logic [7:0] SLICE_HIGH_OFS = 8'h00D7;
  localparam logic [7:0] PAGE_SELECT_OFS = 8'h00DF;
  localparam logic [7:0] SLICE_LOW_RESET = 8'h00C0;
  localparam logic [7:0] SLICE_HIGH_RESET = 8'h00C8;
  localparam logic [7:0] PAGE_SELECT_RESET = 8'h0000;
  localparam logic [7:0] SLICE_STEP = 8'h0008;
  localparam logic [7:0] SET1_BASE = 8'h00C0;
  localparam logic [7:0] COMMON_LAST = 8'h00CF;
  localparam logic [7:0] BANK_BASE = 8'h00E0;
  localparam logic [3:0] WORKING_NIBBLE = 4'h000C;
  localparam logic [3:0] PAGE_COUNT = 4'h0008;
  localparam logic [10:0] PRIME_BYTES = 11'h00C0;
  localparam int PRIME_DEPTH = 1536;
  localparam int SET2_DEPTH = 512;
  localparam logic [1:0] REG_IDX_LOW = 2'h0000;
  localparam logic [1:0] REG_IDX_HIGH = 2'h0001;
  localparam logic [1:0] REG_IDX_PAGE = 2'h0002;

  typedef enum logic [1:0] {
    MODE_DIRECT = 2'h0000,
    MODE_INDIRECT = 2'h0001,
    MODE_INDEXED = 2'h0002,
    MODE_WORKING = 2'h0003
  } mode_t;

  typedef enum logic [2:0] {
    CMD_SELECT_BANK_ZERO = 3'h0000,
    CMD_SELECT_BANK_ONE = 3'h0001,
    CMD_SET_SLICE_POINTERS = 3'h0002,
    CMD_SET_LOW_SLICE_POINTER = 3'h0003,
    CMD_SET_HIGH_SLICE_POINTER = 3'h0004
  } cmd_t;

  typedef enum logic [2:0] {
    T_NONE = 3'h0000,
    T_PRIME = 3'h0001,
    T_SET2 = 3'h0002,
    T_COMMON = 3'h0003,
    T_SYS = 3'h0004,
    T_BANK = 3'h0005,
    T_REG = 3'h0006
  } target_t;

  typedef struct packed {
    target_t kind;
    logic [10:0] index;
  } loc_t;
endpackage : paged_regfile_pkg
`default_nettype wire

// [verilog/paged_regfile.sv]
`timescale 1ns/10ps
`default_nettype none

module paged_regfile
  import paged_regfile_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic REQ_PAIR,
  input wire logic [1:0] REQ_MODE,
  input wire logic [7:0] REQ_ADDR,
  input wire logic [15:0] REQ_WDATA,
  input wire logic CMD_VALID,
  input wire logic [2:0] CMD_OP,
  input wire logic [7:0] CMD_DATA,
  output logic [15:0] RD_DATA,
  output logic RD_VALID,
  output logic ADDR_FAULT,
  output logic BANK_SELECT,
  output logic [7:0] PAGE_SELECT,
  output logic [7:0] SLICE_LOW,
  output logic [7:0] SLICE_HIGH
);

  logic [7:0] prime_mem [0:PRIME_DEPTH-1];
  logic [7:0] set2_mem [0:SET2_DEPTH-1];
  logic [7:0] common_mem [0:15];
  logic [7:0] sys_mem [0:15];
  logic [7:0] bank_mem [0:63];

  mode_t mode;
  cmd_t cmd;
  logic [3:0] page;
  loc_t slot_loc [0:1];
  logic [7:0] slot_data [0:1];
  logic slot_en [0:1];
  logic [7:0] next_rd_hi;
  logic [7:0] next_rd_lo;
  logic next_fault;

  assign mode = mode_t'(REQ_MODE);
  assign cmd = cmd_t'(CMD_OP);
  // Reads take the source nibble, writes the destination nibble.
  assign page = REQ_WRITE ? PAGE_SELECT[7:4] : PAGE_SELECT[3:0];

  function automatic logic is_working(input logic [7:0] a, input mode_t m);
    is_working = (m == MODE_WORKING) ||
                 (m == MODE_DIRECT && a[7:4] == WORKING_NIBBLE);
  endfunction : is_working

  // Folds a working register address onto the pointer's slice.
  function automatic logic [7:0] resolve(input logic [7:0] a,
                                         input mode_t m,
                                         input logic [7:0] low,
                                         input logic [7:0] high);
    logic [7:0] ptr;
    ptr = a[3] ? high : low;
    resolve = is_working(a, m) ? {ptr[7:3], a[2:0]} : a;
  endfunction : resolve

  function automatic loc_t locate(input logic [7:0] a,
                                  input logic work,
                                  input mode_t m,
                                  input logic [3:0] pg,
                                  input logic bank);
    loc_t l;
    l.kind = T_NONE;
    l.index = 11'h0000;
    if (a < SET1_BASE) begin
      if (pg < PAGE_COUNT) begin
        l.kind = T_PRIME;
        l.index = 11'(pg[2:0]) * PRIME_BYTES + 11'(a);
      end
    end else if (!work && (m == MODE_INDIRECT || m == MODE_INDEXED)) begin
      if (pg < PAGE_COUNT) begin
        l.kind = T_SET2;
        l.index = {2'h0000, pg[2:0], a[5:0]};
      end
    end else if (a <= COMMON_LAST) begin
      if (work) begin
        l.kind = T_COMMON;
        l.index = {7'h0000, a[3:0]};
      end
    end else if (a < BANK_BASE) begin
      l.kind = T_SYS;
      l.index = {7'h0000, a[3:0]};
      if (a == SLICE_LOW_OFS) begin
        l.kind = T_REG;
        l.index = {9'h0000, REG_IDX_LOW};
      end else if (a == SLICE_HIGH_OFS) begin
        l.kind = T_REG;
        l.index = {9'h0000, REG_IDX_HIGH};
      end else if (a == PAGE_SELECT_OFS) begin
        l.kind = T_REG;
        l.index = {9'h0000, REG_IDX_PAGE};
      end
    end else begin
      l.kind = T_BANK;
      l.index = {5'h0000, bank, a[4:0]};
    end
    locate = l;
  endfunction : locate

  function automatic logic [7:0] fetch(input loc_t l);
    fetch = 8'h0000;
    case (l.kind)
      T_PRIME: fetch = prime_mem[l.index];
      T_SET2: fetch = set2_mem[l.index[8:0]];
      T_COMMON: fetch = common_mem[l.index[3:0]];
      T_SYS: fetch = sys_mem[l.index[3:0]];
      T_BANK: fetch = bank_mem[l.index[5:0]];
      T_REG: begin
        if (l.index[1:0] == REG_IDX_LOW) begin
          fetch = SLICE_LOW;
        end else if (l.index[1:0] == REG_IDX_HIGH) begin
          fetch = SLICE_HIGH;
        end else begin
          fetch = PAGE_SELECT;
        end
      end
      default: fetch = 8'h0000;
    endcase
  endfunction : fetch

  // Slot 0 is the single byte or the even byte of a pair; slot 1 the odd.
  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1) begin : g_slot
      logic [7:0] raw;
      logic [7:0] eff;
      assign raw = REQ_PAIR ? {REQ_ADDR[7:1], 1'(s)} : REQ_ADDR;
      assign eff = resolve(raw, mode, SLICE_LOW, SLICE_HIGH);
      // Working accesses never carry the indirect mode, so set 2 is out.
      assign slot_loc[s] = locate(eff, is_working(raw, mode), mode, page,
                                  BANK_SELECT);
      assign slot_en[s] = REQ_VALID && (s == 0 || REQ_PAIR);
      assign slot_data[s] = (REQ_PAIR && s == 0) ? REQ_WDATA[15:8] :
                            REQ_WDATA[7:0];
    end
  endgenerate

  always_comb begin
    next_rd_hi = 8'h0000;
    next_rd_lo = fetch(slot_loc[0]);
    if (REQ_PAIR) begin
      next_rd_hi = fetch(slot_loc[0]);
      next_rd_lo = fetch(slot_loc[1]);
    end
    next_fault = (slot_en[0] && slot_loc[0].kind == T_NONE) ||
                 (slot_en[1] && slot_loc[1].kind == T_NONE);
  end

  always_ff @(posedge CLK) begin
    for (int k = 0; k < 2; k++) begin
      if (slot_en[k] && REQ_WRITE) begin
        case (slot_loc[k].kind)
          T_PRIME: prime_mem[slot_loc[k].index] <= slot_data[k];
          T_SET2: set2_mem[slot_loc[k].index[8:0]] <= slot_data[k];
          T_COMMON: common_mem[slot_loc[k].index[3:0]] <= slot_data[k];
          T_SYS: sys_mem[slot_loc[k].index[3:0]] <= slot_data[k];
          T_BANK: bank_mem[slot_loc[k].index[5:0]] <= slot_data[k];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      RD_DATA <= 16'h0000;
      RD_VALID <= 1'b0;
      ADDR_FAULT <= 1'b0;
    end else begin
      RD_VALID <= REQ_VALID && !REQ_WRITE;
      ADDR_FAULT <= next_fault;
      if (REQ_VALID && !REQ_WRITE) begin
        RD_DATA <= {next_rd_hi, next_rd_lo};
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      BANK_SELECT <= 1'b0;
    end else if (CMD_VALID && cmd == CMD_SELECT_BANK_ZERO) begin
      BANK_SELECT <= 1'b0;
    end else if (CMD_VALID && cmd == CMD_SELECT_BANK_ONE) begin
      BANK_SELECT <= 1'b1;
    end
  end

  // A register load in the same cycle as a command takes precedence.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      SLICE_LOW <= SLICE_LOW_RESET;
      SLICE_HIGH <= SLICE_HIGH_RESET;
      PAGE_SELECT <= PAGE_SELECT_RESET;
    end else begin
      if (CMD_VALID && cmd == CMD_SET_SLICE_POINTERS) begin
        SLICE_LOW <= CMD_DATA;
        SLICE_HIGH <= CMD_DATA + SLICE_STEP;
      end else if (CMD_VALID && cmd == CMD_SET_LOW_SLICE_POINTER) begin
        SLICE_LOW <= CMD_DATA;
      end else if (CMD_VALID && cmd == CMD_SET_HIGH_SLICE_POINTER) begin
        SLICE_HIGH <= CMD_DATA;
      end
      for (int k = 0; k < 2; k++) begin
        if (slot_en[k] && REQ_WRITE && slot_loc[k].kind == T_REG) begin
          if (slot_loc[k].index[1:0] == REG_IDX_LOW) begin
            SLICE_LOW <= slot_data[k];
          end else if (slot_loc[k].index[1:0] == REG_IDX_HIGH) begin
            SLICE_HIGH <= slot_data[k];
          end else begin
            PAGE_SELECT <= slot_data[k];
          end
        end
      end
    end
  end

  a_bank_reset: assert property (@(posedge CLK)
    SYS_RST |=> !BANK_SELECT)
    else $error("bank not cleared by reset");

  a_bank_select_one: assert property (@(posedge CLK)
    disable iff (SYS_RST)
    CMD_VALID && cmd == CMD_SELECT_BANK_ONE |=> BANK_SELECT)
    else $error("bank one not selected");

  a_pointer_reset: assert property (@(posedge CLK)
    SYS_RST |=> SLICE_LOW == SLICE_LOW_RESET &&
      SLICE_HIGH == SLICE_HIGH_RESET && PAGE_SELECT == PAGE_SELECT_RESET)
    else $error("pointers not at reset values");

  a_combined_set: assert property (@(posedge CLK)
    disable iff (SYS_RST)
    CMD_VALID && cmd == CMD_SET_SLICE_POINTERS && !REQ_VALID
    |=> SLICE_LOW == $past(CMD_DATA) &&
      SLICE_HIGH == $past(CMD_DATA) + SLICE_STEP)
    else $error("combined slice set wrong");

  a_page_load: assert property (@(posedge CLK)
    disable iff (SYS_RST)
    REQ_VALID && REQ_WRITE && !REQ_PAIR && mode == MODE_DIRECT &&
      REQ_ADDR == PAGE_SELECT_OFS
    |=> PAGE_SELECT == $past(REQ_WDATA[7:0]))
    else $error("page select not loaded");

  a_read_timing: assert property (@(posedge CLK)
    disable iff (SYS_RST)
    REQ_VALID && !REQ_WRITE |=> RD_VALID ##1 !RD_VALID || $past(REQ_VALID))
    else $error("read answer timing wrong");

  a_working_pointer: assert property (@(posedge CLK)
    disable iff (SYS_RST)
    REQ_VALID && !REQ_WRITE && !REQ_PAIR && mode == MODE_WORKING &&
      !REQ_ADDR[3] && {SLICE_LOW[7:3], REQ_ADDR[2:0]} == SLICE_HIGH_OFS
    |=> RD_DATA[7:0] == $past(SLICE_HIGH))
    else $error("working address resolved wrongly");

  a_page_fault: assert property (@(posedge CLK)
    disable iff (SYS_RST)
    REQ_VALID && !REQ_WRITE && mode == MODE_INDIRECT &&
      PAGE_SELECT[3:0] >= PAGE_COUNT |=> ADDR_FAULT)
    else $error("missing page fault");

  a_bank_select_zero: assert property (@(posedge CLK)
    disable iff (SYS_RST)
    CMD_VALID && cmd == CMD_SELECT_BANK_ZERO |=> !BANK_SELECT)
    else $error("bank zero not selected");

  a_bank_hold: assert property (@(posedge CLK)
    disable iff (SYS_RST)
    !CMD_VALID |=> BANK_SELECT == $past(BANK_SELECT))
    else $error("bank changed without a command");

  a_low_pointer_set: assert property (@(posedge CLK)
    disable iff (SYS_RST)
    CMD_VALID && cmd == CMD_SET_LOW_SLICE_POINTER && !REQ_VALID
    |=> SLICE_LOW == $past(CMD_DATA) && SLICE_HIGH == $past(SLICE_HIGH))
    else $error("low slice pointer set wrong");

  a_high_pointer_set: assert property (@(posedge CLK)
    disable iff (SYS_RST)
    CMD_VALID && cmd == CMD_SET_HIGH_SLICE_POINTER && !REQ_VALID
    |=> SLICE_HIGH == $past(CMD_DATA) && SLICE_LOW == $past(SLICE_LOW))
    else $error("high slice pointer set wrong");

  a_unknown_cmd: assert property (@(posedge CLK)
    disable iff (SYS_RST)
    CMD_VALID && CMD_OP > CMD_SET_HIGH_SLICE_POINTER && !REQ_VALID
    |=> SLICE_LOW == $past(SLICE_LOW) && SLICE_HIGH == $past(SLICE_HIGH) &&
      BANK_SELECT == $past(BANK_SELECT))
    else $error("unknown command changed state");

  a_write_no_answer: assert property (@(posedge CLK)
    disable iff (SYS_RST)
    REQ_VALID && REQ_WRITE |=> !RD_VALID)
    else $error("write produced a read answer");

  a_prime_read_ok: assert property (@(posedge CLK)
    disable iff (SYS_RST)
    REQ_VALID && !REQ_WRITE && mode != MODE_WORKING &&
      REQ_ADDR < SET1_BASE && PAGE_SELECT[3:0] < PAGE_COUNT |=> !ADDR_FAULT)
    else $error("backed prime read faulted");

  a_dest_fault: assert property (@(posedge CLK)
    disable iff (SYS_RST)
    REQ_VALID && REQ_WRITE && mode != MODE_WORKING &&
      REQ_ADDR < SET1_BASE && PAGE_SELECT[7:4] >= PAGE_COUNT |=> ADDR_FAULT)
    else $error("write to unbacked page not faulted");

  a_pair_order: assert property (@(posedge CLK)
    disable iff (SYS_RST)
    REQ_VALID && !REQ_WRITE && REQ_PAIR && mode == MODE_DIRECT &&
      REQ_ADDR[7:1] == SLICE_LOW_OFS[7:1]
    |=> RD_DATA == {$past(SLICE_LOW), $past(SLICE_HIGH)})
    else $error("pair read byte order wrong");

endmodule : paged_regfile

`default_nettype wire

// [bench/cpu_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model (
  input wire logic CLK,
  output logic REQ_VALID,
  output logic REQ_WRITE,
  output logic REQ_PAIR,
  output logic [1:0] REQ_MODE,
  output logic [7:0] REQ_ADDR,
  output logic [15:0] REQ_WDATA,
  output logic CMD_VALID,
  output logic [2:0] CMD_OP,
  output logic [7:0] CMD_DATA
);
  initial begin
    {REQ_VALID, REQ_WRITE, REQ_PAIR, REQ_MODE, REQ_ADDR, REQ_WDATA} = '0;
    {CMD_VALID, CMD_OP, CMD_DATA} = '0;
  end
  // Idle lines carry changing junk so a stale value never passes for data.
  task automatic idle();
    @(negedge CLK);
    REQ_VALID = 1'b0;
    CMD_VALID = 1'b0;
    {REQ_WRITE, REQ_PAIR, REQ_MODE, REQ_ADDR} = 12'($urandom);
    REQ_WDATA = 16'($urandom);
    {CMD_OP, CMD_DATA} = 11'($urandom);
  endtask : idle
  task automatic req(input logic w, input logic p, input logic [1:0] m,
                     input logic [7:0] a, input logic [15:0] d);
    @(negedge CLK);
    CMD_VALID = 1'b0;
    {REQ_VALID, REQ_WRITE, REQ_PAIR, REQ_MODE} = {1'b1, w, p, m};
    REQ_ADDR = a;
    REQ_WDATA = d;
    @(posedge CLK);
  endtask : req
  task automatic cmd(input logic [2:0] op, input logic [7:0] d);
    @(negedge CLK);
    REQ_VALID = 1'b0;
    {CMD_VALID, CMD_OP, CMD_DATA} = {1'b1, op, d};
    @(posedge CLK);
  endtask : cmd
endmodule : cpu_core_model
`default_nettype wire

// [bench/paged_regfile_test.sv]
`timescale 1ns/10ps
`default_nettype none
module paged_regfile_test;
  import paged_regfile_pkg::*;
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic REQ_VALID, REQ_WRITE, REQ_PAIR, CMD_VALID, RD_VALID, ADDR_FAULT;
  logic BANK_SELECT;
  logic [1:0] REQ_MODE;
  logic [2:0] CMD_OP;
  logic [7:0] REQ_ADDR, CMD_DATA, PAGE_SELECT, SLICE_LOW, SLICE_HIGH;
  logic [15:0] REQ_WDATA, RD_DATA;
  logic [17:0] exp_q[$];
  logic [17:0] e;
  logic [7:0] pv[8];
  logic [7:0] v;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  always #25 CLK = ~CLK;
  paged_regfile i_paged_regfile (.CLK, .SYS_RST, .REQ_VALID, .REQ_WRITE,
    .REQ_PAIR, .REQ_MODE, .REQ_ADDR, .REQ_WDATA, .CMD_VALID, .CMD_OP,
    .CMD_DATA, .RD_DATA, .RD_VALID, .ADDR_FAULT, .BANK_SELECT,
    .PAGE_SELECT, .SLICE_LOW, .SLICE_HIGH);
  cpu_core_model i_cpu_core_model (.CLK, .REQ_VALID, .REQ_WRITE,
    .REQ_PAIR, .REQ_MODE, .REQ_ADDR, .REQ_WDATA, .CMD_VALID, .CMD_OP,
    .CMD_DATA);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    if (err_total == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic rd(input logic [1:0] m, input logic [7:0] a,
                    input logic [15:0] x, input logic f = 1'b0,
                    input logic p = 1'b0);
    i_cpu_core_model.req(1'b0, p, m, a, 16'($urandom));
    exp_q.push_back({1'b1, f, x});
  endtask : rd
  task automatic wr(input logic [1:0] m, input logic [7:0] a,
                    input logic [15:0] d, input logic f = 1'b0,
                    input logic p = 1'b0);
    i_cpu_core_model.req(1'b1, p, m, a, d);
    if (f) begin
      exp_q.push_back({2'b01, 16'h0000});
    end
  endtask : wr
  task automatic regs(input logic [24:0] x);
    i_cpu_core_model.idle();
    chk({BANK_SELECT, PAGE_SELECT, SLICE_LOW, SLICE_HIGH}, x);
  endtask : regs
  always @(negedge CLK) begin
    if (!SYS_RST && (RD_VALID !== 1'b0 || ADDR_FAULT !== 1'b0)) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 18'h3_FFFF;
      chk({RD_VALID, ADDR_FAULT, e[17] ? RD_DATA : 16'h0000}, e);
    end
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    v = 8'($urandom(32'h4447));
    repeat (5) @(negedge CLK);
    SYS_RST = 1'b0;
    regs({1'b0, 24'h00_C0C8});
    rd(MODE_DIRECT, SLICE_LOW_OFS, 16'h00C0);
    rd(MODE_DIRECT, SLICE_HIGH_OFS, 16'h00C8);
    rd(MODE_DIRECT, PAGE_SELECT_OFS, 16'h0000);
    for (int p = 0; p < 8; p++) begin
      pv[p] = 8'($urandom);
      wr(MODE_DIRECT, PAGE_SELECT_OFS, {8'h00, 4'(p), 4'h0});
      wr(MODE_INDIRECT, 8'h5A, {8'h00, pv[p]});
    end
    for (int p = 0; p < 8; p++) begin
      wr(MODE_DIRECT, PAGE_SELECT_OFS, {8'h00, 4'h8, 4'(p)});
      rd(2'(p % 3), 8'h5A, {8'h00, pv[p]});
    end
    wr(MODE_DIRECT, PAGE_SELECT_OFS, 16'h0088);
    wr(MODE_DIRECT, 8'h10, 16'h0011, 1'b1);
    rd(MODE_DIRECT, 8'h10, 16'h0000, 1'b1);
    rd(MODE_INDIRECT, 8'hE0, 16'h0000, 1'b1);
    wr(MODE_DIRECT, PAGE_SELECT_OFS, 16'h0000);
    wr(MODE_INDIRECT, 8'hE5, 16'h0011);
    wr(MODE_DIRECT, 8'hE5, 16'h0022);
    rd(MODE_INDIRECT, 8'hE5, 16'h0011);
    rd(MODE_DIRECT, 8'hE5, 16'h0022);
    wr(MODE_DIRECT, PAGE_SELECT_OFS, 16'h0011);
    rd(MODE_DIRECT, 8'hE5, 16'h0022);
    wr(MODE_INDEXED, 8'hE5, 16'h0033);
    rd(MODE_INDIRECT, 8'hE5, 16'h0033);
    i_cpu_core_model.cmd(CMD_SELECT_BANK_ONE, 8'h00);
    regs({1'b1, 24'h11_C0C8});
    wr(MODE_DIRECT, 8'hE5, 16'h0044);
    rd(MODE_DIRECT, 8'hE5, 16'h0044);
    i_cpu_core_model.cmd(CMD_SELECT_BANK_ZERO, 8'h00);
    rd(MODE_DIRECT, 8'hE5, 16'h0022);
    wr(MODE_DIRECT, PAGE_SELECT_OFS, 16'h0000);
    i_cpu_core_model.cmd(CMD_SET_SLICE_POINTERS, 8'h70);
    regs({1'b0, 24'h00_7078});
    wr(MODE_WORKING, 8'h06, {8'h00, v});
    rd(MODE_DIRECT, 8'h76, {8'h00, v});
    rd(MODE_DIRECT, 8'hC6, {8'h00, v});
    i_cpu_core_model.cmd(CMD_SET_HIGH_SLICE_POINTER, 8'h70);
    i_cpu_core_model.cmd(CMD_SET_LOW_SLICE_POINTER, 8'hE0);
    regs({1'b0, 24'h00_E070});
    rd(MODE_WORKING, 8'h0E, {8'h00, v});
    rd(MODE_WORKING, 8'h05, 16'h0022);
    wr(MODE_DIRECT, SLICE_LOW_OFS, 16'h00C0);
    wr(MODE_DIRECT, SLICE_HIGH_OFS, 16'h0080);
    regs({1'b0, 24'h00_C080});
    wr(MODE_WORKING, 8'h02, 16'h005C);
    rd(MODE_DIRECT, 8'hC2, 16'h005C);
    wr(MODE_DIRECT, 8'h72, 16'h00A7);
    wr(MODE_DIRECT, SLICE_LOW_OFS, 16'h0070);
    rd(MODE_DIRECT, 8'hC2, 16'h00A7);
    wr(MODE_DIRECT, 8'h21, 16'hABCD, 1'b0, 1'b1);
    rd(MODE_DIRECT, 8'h20, 16'h00AB);
    rd(MODE_DIRECT, 8'h21, 16'h00CD);
    rd(MODE_INDIRECT, 8'h20, 16'hABCD, 1'b0, 1'b1);
    rd(MODE_DIRECT, 8'hD7, 16'h7080, 1'b0, 1'b1);
    i_cpu_core_model.cmd(CMD_SET_LOW_SLICE_POINTER, 8'hD0);
    rd(MODE_WORKING, 8'h07, 16'h0080);
    for (int op = 5; op < 8; op++) begin
      i_cpu_core_model.cmd(3'(op), 8'h10);
    end
    regs({1'b0, 24'h00_D080});
    repeat (2) @(negedge CLK);
    chk(32'(exp_q.size()), 32'h0000_0000);
    stop_test();
  end
endmodule : paged_regfile_test
`default_nettype wire
